// ---- bench/bsfeu_core_props.sv ----
`include "bsfeu_regs.vh"
module bsfeu_core_props (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Instruction
  input wire instValid,
  input wire [4:0] opCode,
  input wire [2:0] bitSel,
  input wire [7:0] rdIn,
  // Results
  input wire [7:0] rdOut,
  input wire rdWrite,
  input wire [2:0] ioBitIdx,
  input wire ioBitValue,
  input wire ioBitWrite,
  input wire breakReq,
  input wire instDone,
  input wire [7:0] statusRegister,
  // Register bus, to follow the execute enable
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow of the enable bit, so refused instructions arm only a_refuse
  logic execOn;
  wire takeInst;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      execOn <= `BSFEU_CONTROL_RESET;
    else if (psel && penable && pready && pwrite && paddr == `BSFEU_ADDR_CONTROL)
      execOn <= pwdata[`BSFEU_CTRL_EXEC_BIT];
  end
  assign takeInst = instValid & execOn;
  property p_shl;
    takeInst && opCode == `BSFEU_OP_SHL |=> rdWrite && rdOut == ($past(rdIn) << 1)
      && statusRegister[0] == $past(rdIn[7]) && statusRegister[5] == $past(rdIn[3]);
  endproperty
  a_shl: assert property (p_shl) else $error("left shift");
  property p_shr;
    takeInst && opCode == `BSFEU_OP_SHR |=> rdOut == ($past(rdIn) >> 1)
      && statusRegister[0] == $past(rdIn[0]);
  endproperty
  a_shr: assert property (p_shr) else $error("right shift");
  property p_rotl;
    takeInst && opCode == `BSFEU_OP_ROTL |=>
      rdOut == {$past(rdIn[6:0]), $past(statusRegister[0])};
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left");
  property p_swap;
    takeInst && opCode == `BSFEU_OP_SWAP |=>
      rdOut == {$past(rdIn[3:0]), $past(rdIn[7:4])} && $stable(statusRegister);
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
  property p_flags;
    takeInst && opCode >= `BSFEU_OP_SHL && opCode <= `BSFEU_OP_ASHR |=>
      statusRegister[1] == (rdOut == 8'h00) && statusRegister[2] == rdOut[7]
      && statusRegister[3] == (rdOut[7] ^ statusRegister[0])
      && statusRegister[4] == (rdOut[7] ^ statusRegister[3]);
  endproperty
  a_flags: assert property (p_flags) else $error("shift flags");
  property p_done;
    takeInst |=> instDone && breakReq == ($past(opCode) == `BSFEU_OP_BRK);
  endproperty
  a_done: assert property (p_done) else $error("done pulse");
  property p_ded;
    takeInst && opCode[4] |=> statusRegister[$past(opCode[2:0])] == $past(opCode[3]);
  endproperty
  a_ded: assert property (p_ded) else $error("flag op");
  property p_io;
    takeInst && opCode == `BSFEU_OP_IOSET |=> ioBitWrite && ioBitValue
      && ioBitIdx == $past(bitSel) && $stable(statusRegister);
  endproperty
  a_io: assert property (p_io) else $error("io set");
  property p_refuse;
    instValid && !execOn |=> !instDone && !rdWrite && $stable(statusRegister);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused instruction ran");
endmodule
bind bsfeu_core bsfeu_core_props u_props (.clk, .rstn, .instValid, .opCode, .bitSel,
  .rdIn, .rdOut, .rdWrite, .ioBitIdx, .ioBitValue, .ioBitWrite, .breakReq, .instDone,
  .statusRegister, .psel, .penable, .pwrite, .paddr, .pwdata, .pready);

// ---- bench/bsfeu_rf_model.sv ----
module bsfeu_rf_model (
  // Clock
  input wire logic clk,
  // Write back and I/O bit writes
  input wire logic [7:0] rdOut,
  input wire logic rdWrite,
  input wire logic [5:0] ioAddrOut,
  input wire logic [2:0] ioBitIdx,
  input wire logic ioBitValue,
  input wire logic ioBitWrite,
  // Operand to the unit
  output logic [7:0] rdIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] io [64];
  always @(posedge clk)
  begin
    if (rdWrite)
      rdIn <= rdOut;
    if (ioBitWrite)
      io[ioAddrOut][ioBitIdx] <= ioBitValue;
  end
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, instValid = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [4:0] opCode = 0;
  logic [2:0] bitSel = 0;
  logic [5:0] ioAddr = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [7:0] rdIn, sr, r;
  logic [7:0] v [3] = '{8'h81, 8'h00, 8'h48};
  int n_errors = 0, cmp_count = 0;
  wire [7:0] rdOut, statusRegister;
  wire [5:0] ioAddrOut;
  wire [2:0] ioBitIdx;
  wire [31:0] prdata;
  wire rdWrite, ioBitValue, ioBitWrite, breakReq, sleepReq, wdtRestartReq;
  wire instDone, pready, pslverr;
  bsfeu_core uut (.clk, .rstn, .instValid, .opCode, .bitSel, .ioAddr, .rdIn, .rdOut,
    .rdWrite, .ioAddrOut, .ioBitIdx, .ioBitValue, .ioBitWrite, .breakReq, .sleepReq,
    .wdtRestartReq, .instDone, .statusRegister, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr);
  bsfeu_rf_model pm (.clk, .rdOut, .rdWrite, .ioAddrOut, .ioBitIdx, .ioBitValue,
    .ioBitWrite, .rdIn);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  function automatic [15:0] model(input [4:0] op, input [2:0] b, input [7:0] a,
    input [7:0] s);
    logic [7:0] t;
    logic c, n, sh;
    begin
      t = a;
      c = s[0];
      sh = 1;
      case (op)
        1: {c, t} = {a, 1'b0};
        2: {t, c} = {1'b0, a};
        3: {c, t} = {a, s[0]};
        4: {t, c} = {s[0], a};
        5: {t, c} = {a[7], a};
        default: sh = 0;
      endcase
      if (sh)
      begin
        n = t[7];
        s[4:0] = {c, n ^ c, n, t == 8'h00, c};
        if (op == 1 || op == 3)
          s[5] = a[3];
      end
      case (op)
        6: t = {a[3:0], a[7:4]};
        7: s[b] = 1;
        8: s[b] = 0;
        11: s[6] = a[b];
        12: t[b] = s[6];
      endcase
      if (op[4])
        s[op[2:0]] = op[3];
      model = {t, s};
    end
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask
  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task ap(input w, input [11:0] a, input [31:0] d);
    int k;
    begin
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (pready !== 1 && k < 20);
      if (pready !== 1)
      begin
        n_errors++;
        end_sim;
      end
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task ex(input int op, input [2:0] b, input [7:0] a, input bit en = 1);
    logic [3:0] p;
    @(posedge clk);
    instValid <= 1;
    opCode <= 5'(op);
    bitSel <= b;
    ioAddr <= 6'h2A;
    pm.rdIn <= a;
    // Write-back and unit request pulses expected from the op class
    p = {(op > 0 && op < 7) || op == 12, op == 13, op == 14, op == 15};
    if (en)
      {r, sr} = model(5'(op), b, a, sr);
    else
    begin
      p = 4'h0;
      r = a;
    end
    @(posedge clk);
    instValid <= 0;
    @(negedge clk);
    chk(instDone, en);
    chk({rdWrite, breakReq, sleepReq, wdtRestartReq}, p);
    @(posedge clk);
    #1;
    chk(pm.rdIn, r);
    chk(statusRegister, sr);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    // Register reset values, unmapped place, write then read
    ap(0, 12'h008, 0);
    chk(q, 1);
    ap(0, 12'h000, 0);
    chk(q, 0);
    ap(0, 12'h010, 0);
    chk(e, 1);
    ap(1, 12'h000, 32'h0000_00A5);
    ap(0, 12'h000, 0);
    chk(q, 32'h0000_00A5);
    sr = 8'hA5;
    $display("test registers done");
    for (int o = 1; o < 7; o++)
      for (int i = 0; i < 3; i++)
        ex(o, 0, v[i]);
    // Last write-back was the final swap
    ap(0, 12'h004, 0);
    chk(q, {24'h00_0000, r});
    $display("test shifts done");
    for (int b = 0; b < 8; b++)
    begin
      ex(7, b, 8'h3C);
      ex(11, b, 8'h3C);
      ex(12, b, 8'h00);
      ex(8, b, 8'h3C);
    end
    ex(9, 5, 0);
    chk(pm.io[42][5], 1);
    ex(10, 5, 0);
    chk(pm.io[42][5], 0);
    for (int o = 16; o < 32; o++)
      ex(o, 0, 8'h5A);
    for (int o = 13; o < 16; o++)
      ex(o, 0, 8'h11);
    ex(0, 0, 8'h22);
    $display("test bit and control done");
    // Execution disabled: instructions refused, count stays at 72
    ap(1, 12'h008, 0);
    ex(1, 0, 8'h81, 0);
    ex(13, 0, 8'h81, 0);
    ap(0, 12'h00C, 0);
    chk(q, 32'h0000_0048);
    ap(1, 12'h008, 1);
    $display("test count and refusal done");
    end_sim;
  end
endmodule

// ---- design/bsfeu_core.v ----
// What this block does
// [RULE1] Left shift: bits up, zero into bit 0, old bit 7 to carry; one cycle.
// [RULE2] Right shift: bits down, zero into bit 7, old bit 0 to carry.
// [RULE3] Rotate left through carry: old carry into bit 0, bit 7 to carry.
// [RULE4] Rotate right through carry: old carry into bit 7, bit 0 to carry.
// [RULE5] Arithmetic right shift keeps the sign bit, one cycle.
// [RULE6] Nibble swap exchanges halves, flags untouched, one cycle.
// [RULE7] Status set/clear forces only the selected status bit.
// [RULE8] I/O bit set/clear writes the chosen bit, no flag change.
// [RULE9] Bit store copies register bit to T; bit load copies T back.
// [RULE10] Interrupt enable sets I, disable clears I, nothing else.
// [RULE11] Dedicated ops set or clear one named flag each.
// [RULE12] All shift, rotate, swap, flag and transfer ops take one cycle.
// [RULE13] Idle instruction changes nothing and takes one cycle.
// [RULE14] Break, sleep, watchdog restart pulse their request, one cycle.
// [RULE15] Shift flags: Z on zero, N is bit 7, V is N^C, S is N^V.
// [RULE16] Left shift and rotate left load H from operand bit 3.
`include "bsfeu_regs.vh"

module bsfeu_core (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Instruction from decoder
  input wire instValid,
  input wire [4:0] opCode,
  input wire [2:0] bitSel,
  input wire [5:0] ioAddr,
  input wire [7:0] rdIn,
  // Register file write back
  output reg [7:0] rdOut,
  output reg rdWrite,
  // I/O bit write
  output reg [5:0] ioAddrOut,
  output reg [2:0] ioBitIdx,
  output reg ioBitValue,
  output reg ioBitWrite,
  // Requests to debug, power and watchdog units
  output reg breakReq,
  output reg sleepReq,
  output reg wdtRestartReq,
  // Completion and status register
  output reg instDone,
  output reg [7:0] statusRegister,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr
);

  reg [7:0] lastResult;
  reg execEnable;
  reg [15:0] instCount;

  reg [7:0] next_statusRegister;
  reg [7:0] next_rdOut;
  reg next_rdWrite;
  reg next_ioBitValue;
  reg next_ioBitWrite;
  reg next_breakReq;
  reg next_sleepReq;
  reg next_wdtRestartReq;
  reg [31:0] next_prdata;
  reg next_pslverr;

  wire execute;
  wire apbAccess;
  wire apbCommit;
  wire [7:0] shResult;
  wire shCarry;
  wire shZero;
  wire shNeg;
  wire shOvf;
  wire shSign;
  wire shHalf;

  // One-hot mask for a bit index
  function [7:0] bitMask;
    input [2:0] idx;
    begin
      bitMask = 8'h01 << idx;
    end
  endfunction

  // Address match, used by both read and write paths
  function addrHit;
    input [11:0] addr;
    input [11:0] target;
    begin
      addrHit = (addr == target);
    end
  endfunction

  // Refused while execution is disabled by software
  assign execute = instValid & execEnable;
  assign apbAccess = psel & penable;
  assign apbCommit = apbAccess & pready;

  bsfeu_shifter uShifter (
    .opCode(opCode),
    .operand(rdIn),
    .carryIn(statusRegister[`BSFEU_FLAG_C]),
    .result(shResult),
    .carryOut(shCarry),
    .zeroOut(shZero),
    .negOut(shNeg),
    .ovfOut(shOvf),
    .signOut(shSign),
    .halfOut(shHalf)
  );

  always @*
  begin
    next_statusRegister = statusRegister;
    next_rdOut = rdIn;
    next_rdWrite = 1'b0;
    next_ioBitValue = 1'b0;
    next_ioBitWrite = 1'b0;
    next_breakReq = 1'b0;
    next_sleepReq = 1'b0;
    next_wdtRestartReq = 1'b0;
    // Software write; an instruction in the same cycle overrides it
    if (apbCommit && pwrite && addrHit(paddr, `BSFEU_ADDR_STATUS))
    begin
      next_statusRegister = pwdata[7:0];
    end
    if (execute)
    begin
      next_statusRegister = statusRegister;
      if (opCode[`BSFEU_OP_DEDICATED_BIT])
      begin
        // [RULE10] [RULE11] Single named flag
        next_statusRegister[opCode[2:0]] = opCode[`BSFEU_OP_VALUE_BIT];
      end
      else
      begin
        case (opCode)
          // [RULE1] [RULE3] [RULE16] Left ops with half carry
          `BSFEU_OP_SHL, `BSFEU_OP_ROTL:
          begin
            next_rdOut = shResult;
            next_rdWrite = 1'b1;
            next_statusRegister[`BSFEU_FLAG_C] = shCarry;
            next_statusRegister[`BSFEU_FLAG_Z] = shZero;
            next_statusRegister[`BSFEU_FLAG_N] = shNeg;
            next_statusRegister[`BSFEU_FLAG_V] = shOvf;
            next_statusRegister[`BSFEU_FLAG_S] = shSign;
            next_statusRegister[`BSFEU_FLAG_H] = shHalf;
          end
          // [RULE2] [RULE4] [RULE5] Right ops keep half carry
          `BSFEU_OP_SHR, `BSFEU_OP_ROTR, `BSFEU_OP_ASHR:
          begin
            next_rdOut = shResult;
            next_rdWrite = 1'b1;
            next_statusRegister[`BSFEU_FLAG_C] = shCarry;
            next_statusRegister[`BSFEU_FLAG_Z] = shZero;
            next_statusRegister[`BSFEU_FLAG_N] = shNeg;
            next_statusRegister[`BSFEU_FLAG_V] = shOvf;
            next_statusRegister[`BSFEU_FLAG_S] = shSign;
          end
          // [RULE6] Nibble swap
          `BSFEU_OP_SWAP:
          begin
            next_rdOut = {rdIn[3:0], rdIn[7:4]};
            next_rdWrite = 1'b1;
          end
          // [RULE7] Selected status bit
          `BSFEU_OP_STSET:
          begin
            next_statusRegister = statusRegister | bitMask(bitSel);
          end
          `BSFEU_OP_STCLR:
          begin
            next_statusRegister = statusRegister & ~bitMask(bitSel);
          end
          // [RULE8] I/O bit write
          `BSFEU_OP_IOSET:
          begin
            next_ioBitValue = 1'b1;
            next_ioBitWrite = 1'b1;
          end
          `BSFEU_OP_IOCLR:
          begin
            next_ioBitValue = 1'b0;
            next_ioBitWrite = 1'b1;
          end
          // [RULE9] Register bit to T
          `BSFEU_OP_TSTORE:
          begin
            next_statusRegister[`BSFEU_FLAG_T] = rdIn[bitSel];
          end
          // [RULE9] T to register bit
          `BSFEU_OP_TLOAD:
          begin
            if (statusRegister[`BSFEU_FLAG_T])
            begin
              next_rdOut = rdIn | bitMask(bitSel);
            end
            else
            begin
              next_rdOut = rdIn & ~bitMask(bitSel);
            end
            next_rdWrite = 1'b1;
          end
          // [RULE14] Unit requests
          `BSFEU_OP_BRK:
          begin
            next_breakReq = 1'b1;
          end
          `BSFEU_OP_SLP:
          begin
            next_sleepReq = 1'b1;
          end
          `BSFEU_OP_WDOG:
          begin
            next_wdtRestartReq = 1'b1;
          end
          // [RULE13] Idle changes nothing
          default:
          begin
            next_rdWrite = 1'b0;
          end
        endcase
      end
    end
  end

  // Read data is captured in the first access cycle
  always @*
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (addrHit(paddr, `BSFEU_ADDR_STATUS))
    begin
      next_prdata = {24'h00_0000, statusRegister};
    end
    else if (addrHit(paddr, `BSFEU_ADDR_RESULT))
    begin
      next_prdata = {24'h00_0000, lastResult};
    end
    else if (addrHit(paddr, `BSFEU_ADDR_CONTROL))
    begin
      next_prdata = {31'h0000_0000, execEnable};
    end
    else if (addrHit(paddr, `BSFEU_ADDR_COUNT))
    begin
      next_prdata = {16'h0000, instCount};
    end
    else
    begin
      next_pslverr = 1'b1;
    end
  end

  // [RULE12] Results land at the next edge
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      statusRegister <= `BSFEU_STATUS_RESET;
      rdOut <= `BSFEU_RESULT_RESET;
      rdWrite <= 1'b0;
      ioAddrOut <= 6'h00;
      ioBitIdx <= 3'h0;
      ioBitValue <= 1'b0;
      ioBitWrite <= 1'b0;
      breakReq <= 1'b0;
      sleepReq <= 1'b0;
      wdtRestartReq <= 1'b0;
      instDone <= 1'b0;
      lastResult <= `BSFEU_RESULT_RESET;
      instCount <= `BSFEU_COUNT_RESET;
    end
    else
    begin
      statusRegister <= next_statusRegister;
      rdOut <= next_rdOut;
      rdWrite <= next_rdWrite;
      ioAddrOut <= ioAddr;
      ioBitIdx <= bitSel;
      ioBitValue <= next_ioBitValue;
      ioBitWrite <= next_ioBitWrite;
      breakReq <= next_breakReq;
      sleepReq <= next_sleepReq;
      wdtRestartReq <= next_wdtRestartReq;
      instDone <= execute;
      if (next_rdWrite)
      begin
        lastResult <= next_rdOut;
      end
      if (execute)
      begin
        instCount <= instCount + 16'h0001;
      end
    end
  end

  // APB slave: one wait state, so every output is a flop
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      execEnable <= `BSFEU_CONTROL_RESET;
    end
    else
    begin
      pready <= apbAccess & ~pready;
      if (apbAccess && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end
      else if (!apbAccess)
      begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
      if (apbCommit && pwrite && addrHit(paddr, `BSFEU_ADDR_CONTROL))
      begin
        execEnable <= pwdata[`BSFEU_CTRL_EXEC_BIT];
      end
    end
  end

endmodule

// ---- design/bsfeu_regs.vh ----
`ifndef BSFEU_REGS_VH
`define BSFEU_REGS_VH

// APB byte addresses
`define BSFEU_ADDR_STATUS 12'h000
`define BSFEU_ADDR_RESULT 12'h004
`define BSFEU_ADDR_CONTROL 12'h008
`define BSFEU_ADDR_COUNT 12'h00C

// Reset values
`define BSFEU_STATUS_RESET 8'h00
`define BSFEU_RESULT_RESET 8'h00
`define BSFEU_CONTROL_RESET 1'h1
`define BSFEU_COUNT_RESET 16'h0000

// Control register fields
`define BSFEU_CTRL_EXEC_BIT 0

// Status register flag positions
`define BSFEU_FLAG_C 3'h0
`define BSFEU_FLAG_Z 3'h1
`define BSFEU_FLAG_N 3'h2
`define BSFEU_FLAG_V 3'h3
`define BSFEU_FLAG_S 3'h4
`define BSFEU_FLAG_H 3'h5
`define BSFEU_FLAG_T 3'h6
`define BSFEU_FLAG_I 3'h7

// Operation codes
`define BSFEU_OP_IDLE 5'h00
`define BSFEU_OP_SHL 5'h01
`define BSFEU_OP_SHR 5'h02
`define BSFEU_OP_ROTL 5'h03
`define BSFEU_OP_ROTR 5'h04
`define BSFEU_OP_ASHR 5'h05
`define BSFEU_OP_SWAP 5'h06
`define BSFEU_OP_STSET 5'h07
`define BSFEU_OP_STCLR 5'h08
`define BSFEU_OP_IOSET 5'h09
`define BSFEU_OP_IOCLR 5'h0A
`define BSFEU_OP_TSTORE 5'h0B
`define BSFEU_OP_TLOAD 5'h0C
`define BSFEU_OP_BRK 5'h0D
`define BSFEU_OP_SLP 5'h0E
`define BSFEU_OP_WDOG 5'h0F
// Dedicated flag ops: bit 4 set, bit 3 = value, bits 2:0 = flag
`define BSFEU_OP_DEDICATED_BIT 4
`define BSFEU_OP_VALUE_BIT 3

// Every operation of this unit completes in one clock
`define BSFEU_EXEC_CYCLES 1

`endif

// ---- design/bsfeu_shifter.v ----
`include "bsfeu_regs.vh"

module bsfeu_shifter (
  // Operation and operand
  input wire [4:0] opCode,
  input wire [7:0] operand,
  input wire carryIn,
  // Result and flags
  output reg [7:0] result,
  output reg carryOut,
  output wire zeroOut,
  output wire negOut,
  output wire ovfOut,
  output wire signOut,
  output wire halfOut
);

  wire [7:0] upBits;
  wire [7:0] downBits;

  // Neighbour wiring shared by every shift flavour
  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1)
    begin : gNeighbour
      assign upBits[i + 1] = operand[i];
      assign downBits[i] = operand[i + 1];
    end
  endgenerate
  assign upBits[0] = 1'b0;
  assign downBits[7] = 1'b0;

  always @*
  begin
    result = operand;
    carryOut = carryIn;
    case (opCode)
      // [RULE1] Shift left, zero fill
      `BSFEU_OP_SHL:
      begin
        result = upBits;
        carryOut = operand[7];
      end
      // [RULE2] Shift right, zero fill
      `BSFEU_OP_SHR:
      begin
        result = downBits;
        carryOut = operand[0];
      end
      // [RULE3] Rotate left via carry
      `BSFEU_OP_ROTL:
      begin
        result = {upBits[7:1], carryIn};
        carryOut = operand[7];
      end
      // [RULE4] Rotate right via carry
      `BSFEU_OP_ROTR:
      begin
        result = {carryIn, downBits[6:0]};
        carryOut = operand[0];
      end
      // [RULE5] Sign bit kept
      `BSFEU_OP_ASHR:
      begin
        result = {operand[7], downBits[6:0]};
        carryOut = operand[0];
      end
      default:
      begin
        result = operand;
        carryOut = carryIn;
      end
    endcase
  end

  // [RULE15] Derived result flags
  assign zeroOut = (result == 8'h00);
  assign negOut = result[7];
  assign ovfOut = negOut ^ carryOut;
  assign signOut = negOut ^ ovfOut;
  // [RULE16] Bit 3 moves into bit 4
  assign halfOut = operand[3];

endmodule
